// file: rtl/dri_core.sv
// drum integrator run gating, z-line precession, fill and adder support
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - button arms; next first position starts run
// - arm clears one pulse after run sets
// - non-continuous run stops after one revolution
// - continuous: overflow sets halt, next start stops
// - first integrator adds integrand into remainder
// - marker written only with switch and run
// - z read passes three stage delay chain
// - idle: z recirculates from middle stage
// - continuous compute: z rewritten from last stage
// - single revolution mode precesses only while running
// - fills and step right: 47 loop in section
// - step left: 49 loop in section
// - fill timing reference from middle stage
// - buttons set fill bit, held until opposite
// - integrand write is run, bit, section, marker
// - remainder fill writes remainder; step right writes none
// - dy tally counts to seven, feeds, clears
// - dx direction from z and remainder code
// - integrand adder carry delayed one pulse
// - remainder carry injects one when subtracting
// - position counter 8..31 halves plus half stage
// - section counter 10..31, twenty-two sections
// - begin flag after position 23 until 47
module dri_core (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       drum_pulse_in,
   input  wire logic       one_btn_in,
   input  wire logic       zero_btn_in,
   input  wire logic       ovf_rd_in,
   input  wire logic       integrand_rd_in,
   input  wire logic       remainder_rd_in,
   input  wire logic       dy_pickup_in,
   input  wire logic [3:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [31:0]     reg_rdata_out,
   output logic            run_out,
   output logic            ovf_wr_out,
   output logic            integrand_wr_out,
   output logic            integrand_wr_en_out,
   output logic            remainder_wr_out,
   output logic            remainder_wr_en_out
);

   // control register and run state
   logic [9:0] ctrl_q;
   logic       arm_q;
   logic       run_q;
   logic       halt_q;
   logic       fill_bit_q;
   // drum indexing counters
   logic [4:0] pos_low_q;
   logic       pos_half_q;
   logic [4:0] sec_q;
   // z delay chain
   logic       z0_q;
   logic       za_q;
   logic       zb_q;
   // arithmetic support
   logic [3:0] tally_q;
   logic       dx_q;
   logic       c1_q;
   logic       c2_q;
   logic       begin_q;
   // track write registers and the read data register
   logic       ovf_wr_q;
   logic       int_wr_q;
   logic       int_en_q;
   logic       rem_wr_q;
   logic       rem_en_q;
   logic [31:0] rdata_q;

   logic [2:0] mode;
   logic       marker_sw;
   logic [4:0] sel_sec;
   logic [5:0] pos;
   logic [4:0] sec;
   logic       first_pt;
   logic       last_pt;
   logic       in_sel;
   logic       in_code;
   logic       fill_mode;
   logic       compute_mode;
   logic       dy_bit;
   logic       y_sum;
   logic       y_carry;
   logic       y_op;
   logic       r_sum;
   logic       r_carry;
   logic       pulse;

   // decoded position 1..48 from the split counter
   function automatic logic [5:0] pos_num(input logic half, input logic [4:0] low);
      logic [5:0] base;
      base = half ? dri_pkg::HALF_LEN : 6'h00;
      pos_num = base + {1'b0, low} - {1'b0, dri_pkg::POS_LOW_RELOAD} + 6'h01;
   endfunction

   assign pulse        = drum_pulse_in;
   assign mode         = ctrl_q[dri_pkg::CTRL_MODE_LSB +: 3];
   assign marker_sw    = ctrl_q[dri_pkg::CTRL_MARK_BIT];
   assign sel_sec      = ctrl_q[dri_pkg::CTRL_SEL_LSB +: 5];
   assign pos          = pos_num(pos_half_q, pos_low_q);
   assign sec          = sec_q - dri_pkg::SEC_RELOAD + 5'h01;
   assign first_pt     = (pos == dri_pkg::POS_FIRST) && (sec == dri_pkg::SEC_FIRST);
   assign last_pt      = (pos == dri_pkg::POS_LAST) && (sec == dri_pkg::SEC_FIRST);
   assign in_sel       = (sec == sel_sec);
   assign in_code      = (pos <= dri_pkg::POS_CODE_END);
   assign fill_mode    = (mode == dri_pkg::MODE_FILL_INTEGRAND) ||
                         (mode == dri_pkg::MODE_FILL_REMAINDER);
   assign compute_mode = (mode == dri_pkg::MODE_SINGLE_REV) ||
                         (mode == dri_pkg::MODE_CONTINUOUS);

   // integrand serial adder: integrand plus tally bit
   assign dy_bit  = begin_q & tally_q[0];
   assign y_sum   = integrand_rd_in ^ dy_bit ^ c1_q;
   assign y_carry = (integrand_rd_in & dy_bit) | (c1_q & (integrand_rd_in ^ dy_bit));
   // remainder adder: remainder plus integrand or its inverse
   assign y_op    = dx_q ? integrand_rd_in : ~integrand_rd_in;
   assign r_sum   = remainder_rd_in ^ y_op ^ c2_q;
   assign r_carry = (remainder_rd_in & y_op) | (c2_q & (remainder_rd_in ^ y_op));

   // position counter: low stages 8..31 then reload, half stage toggles
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pos_low_q  <= dri_pkg::POS_LOW_RELOAD;
         pos_half_q <= 1'b0;
      end else if (pulse) begin
         if (pos_low_q == dri_pkg::POS_LOW_FULL) begin
            pos_low_q  <= dri_pkg::POS_LOW_RELOAD;
            pos_half_q <= ~pos_half_q;
         end else begin
            pos_low_q <= pos_low_q + 5'h01;
         end
      end
   end

   // section counter steps at the end of each 48 pulse section
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sec_q <= dri_pkg::SEC_RELOAD;
      end else if (pulse && pos == dri_pkg::POS_LAST) begin
         if (sec_q == dri_pkg::SEC_FULL) begin
            sec_q <= dri_pkg::SEC_RELOAD;
         end else begin
            sec_q <= sec_q + 5'h01;
         end
      end
   end

   // buttons are taken on any system clock so a short press is not missed
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         arm_q <= 1'b0;
      end else if (one_btn_in || zero_btn_in) begin
         arm_q <= 1'b1;
      end else if (pulse && run_q) begin
         arm_q <= 1'b0;
      end
   end

   // fill bit follows the last button pressed
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         fill_bit_q <= 1'b0;
      end else if (one_btn_in) begin
         fill_bit_q <= 1'b1;
      end else if (zero_btn_in) begin
         fill_bit_q <= 1'b0;
      end
   end

   // run starts and stops only between the last and first sections
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         run_q <= 1'b0;
      end else if (pulse && first_pt) begin
         if (run_q && (mode != dri_pkg::MODE_CONTINUOUS || halt_q)) begin
            run_q <= 1'b0;
         end else if (arm_q) begin
            run_q <= 1'b1;
         end
      end
   end

   // halt catches the first integrator's overflow at its last position
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         halt_q <= 1'b0;
      end else if (pulse) begin
         if (first_pt) begin
            halt_q <= 1'b0;
         end else if (last_pt && run_q && mode == dri_pkg::MODE_CONTINUOUS && c2_q) begin
            halt_q <= 1'b1;
         end
      end
   end

   // three stage delay at the z read end
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         z0_q <= 1'b0;
         za_q <= 1'b0;
         zb_q <= 1'b0;
      end else if (pulse) begin
         z0_q <= ovf_rd_in;
         za_q <= z0_q;
         zb_q <= za_q;
      end
   end

   // z record source picks the loop length; marker and overflow override
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ovf_wr_q <= 1'b0;
      end else if (pulse) begin
         if (run_q && marker_sw && pos == dri_pkg::POS_LAST) begin
            ovf_wr_q <= 1'b1;
         end else if (!run_q) begin
            ovf_wr_q <= za_q;
         end else if (compute_mode) begin
            // overflows enter at position 48, the rest precess one step
            ovf_wr_q <= (pos == dri_pkg::POS_LAST) ? c2_q : zb_q;
         end else if (in_sel && mode == dri_pkg::MODE_STEP_LEFT) begin
            ovf_wr_q <= zb_q;
         end else if (in_sel) begin
            ovf_wr_q <= z0_q;
         end else begin
            ovf_wr_q <= za_q;
         end
      end
   end

   // start flag spans the number part of the section
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         begin_q <= 1'b0;
      end else if (pulse) begin
         if (pos == dri_pkg::POS_BEGIN_END) begin
            begin_q <= 1'b0;
         end else if (pos > dri_pkg::POS_CODE_END && integrand_rd_in) begin
            begin_q <= 1'b1;
         end
      end
   end

   // dy tally counts code pickups, then shifts out into the adder
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         tally_q <= 4'h0;
      end else if (pulse) begin
         if (pos == dri_pkg::POS_LAST) begin
            tally_q <= 4'h0;
         end else if (begin_q) begin
            tally_q <= {1'b0, tally_q[3:1]};
         end else if (in_code && dy_pickup_in && tally_q != dri_pkg::TALLY_MAX) begin
            tally_q <= tally_q + 4'h1;
         end
      end
   end

   // dx direction latched from z where remainder carries its code pulse
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         dx_q <= 1'b0;
      end else if (pulse && in_code && remainder_rd_in) begin
         dx_q <= z0_q;
      end
   end

   // integrand carry delay, cleared outside the number part
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         c1_q <= 1'b0;
      end else if (pulse) begin
         c1_q <= begin_q ? y_carry : 1'b0;
      end
   end

   // remainder carry preset at position 24: one forms the complement
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         c2_q <= 1'b0;
      end else if (pulse) begin
         if (pos == dri_pkg::POS_SPLIT) begin
            c2_q <= ~dx_q;
         end else if (pos > dri_pkg::POS_SPLIT) begin
            c2_q <= r_carry;
         end
      end
   end

   // integrand track: fill coincidence or adder sum while computing
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         int_wr_q <= 1'b0;
         int_en_q <= 1'b0;
      end else if (pulse) begin
         if (mode == dri_pkg::MODE_FILL_INTEGRAND) begin
            // reference from the middle stage marks the digit slot
            int_en_q <= run_q && in_sel && za_q;
            int_wr_q <= run_q && fill_bit_q && in_sel && za_q;
         end else begin
            int_en_q <= run_q && compute_mode && begin_q;
            int_wr_q <= run_q && compute_mode && begin_q && y_sum;
         end
      end
   end

   // remainder track: fill coincidence or adder sum; step modes leave it
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rem_wr_q <= 1'b0;
         rem_en_q <= 1'b0;
      end else if (pulse) begin
         if (mode == dri_pkg::MODE_FILL_REMAINDER) begin
            rem_en_q <= run_q && in_sel && za_q;
            rem_wr_q <= run_q && fill_bit_q && in_sel && za_q;
         end else begin
            // position 48 of the remainder is left untouched
            rem_en_q <= run_q && compute_mode && pos > dri_pkg::POS_SPLIT &&
                        pos != dri_pkg::POS_LAST;
            rem_wr_q <= run_q && compute_mode && pos > dri_pkg::POS_SPLIT && r_sum;
         end
      end
   end

   // control register write
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= dri_pkg::CTRL_RESET;
      end else if (reg_wr_in && reg_addr_in == dri_pkg::CTRL_ADDR) begin
         ctrl_q <= reg_wdata_in[9:0];
      end
   end

   // read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            dri_pkg::CTRL_ADDR:   rdata_q <= {22'h00_0000, ctrl_q};
            dri_pkg::STATUS_ADDR: rdata_q <= {22'h00_0000, tally_q, begin_q, dx_q,
                                              fill_bit_q, halt_q, arm_q, run_q};
            dri_pkg::SECTOR_ADDR: rdata_q <= {21'h00_0000, sec, pos};
            default:              rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign reg_rdata_out       = rdata_q;
   assign run_out             = run_q;
   assign ovf_wr_out          = ovf_wr_q;
   assign integrand_wr_out    = int_wr_q;
   assign integrand_wr_en_out = int_en_q;
   assign remainder_wr_out    = rem_wr_q;
   assign remainder_wr_en_out = rem_en_q;

endmodule
`default_nettype wire

// file: rtl/dri_pkg.sv
// constants for the drum integrator run and fill sequencer
package dri_pkg;
   // register map, byte addresses on the plain register port
   localparam logic [3:0] CTRL_ADDR    = 4'h0;
   localparam logic [3:0] STATUS_ADDR  = 4'h4;
   localparam logic [3:0] SECTOR_ADDR  = 4'h8;
   // control register fields
   localparam int         CTRL_MODE_LSB  = 0;
   localparam int         CTRL_MARK_BIT  = 3;
   localparam int         CTRL_SEL_LSB   = 4;
   localparam logic [9:0] CTRL_RESET     = 10'h001;
   // operating modes held in the control register
   localparam logic [2:0] MODE_FILL_INTEGRAND = 3'h0;
   localparam logic [2:0] MODE_FILL_REMAINDER = 3'h1;
   localparam logic [2:0] MODE_STEP_LEFT      = 3'h2;
   localparam logic [2:0] MODE_STEP_RIGHT     = 3'h3;
   localparam logic [2:0] MODE_SINGLE_REV     = 3'h4;
   localparam logic [2:0] MODE_CONTINUOUS     = 3'h5;
   // position counter: five low stages run 8..31, sixth marks the half
   localparam logic [4:0] POS_LOW_RELOAD = 5'h08;
   localparam logic [4:0] POS_LOW_FULL   = 5'h1f;
   localparam logic [5:0] HALF_LEN       = 6'h18;
   // section counter: five stages run 10..31, 22 sections
   localparam logic [4:0] SEC_RELOAD     = 5'h0a;
   localparam logic [4:0] SEC_FULL       = 5'h1f;
   // positions in a 48 pulse section, numbered 1..48
   localparam logic [5:0] POS_FIRST      = 6'h01;
   localparam logic [5:0] POS_CODE_END   = 6'h17;
   localparam logic [5:0] POS_SPLIT      = 6'h18;
   localparam logic [5:0] POS_BEGIN_END  = 6'h2f;
   localparam logic [5:0] POS_LAST       = 6'h30;
   localparam logic [4:0] SEC_FIRST      = 5'h01;
   // dy tally saturates here
   localparam logic [3:0] TALLY_MAX      = 4'h7;
endpackage

// file: test/dri_core_properties.sv
// port assertions for the drum integrator run and fill sequencer
`timescale 1ns/100ps
`default_nettype none
module dri_core_chk (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        drum_pulse_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_rdata_out,
   input  wire logic        run_out,
   input  wire logic        ovf_wr_out,
   input  wire logic        integrand_wr_out,
   input  wire logic        integrand_wr_en_out,
   input  wire logic        remainder_wr_out,
   input  wire logic        remainder_wr_en_out
);
   localparam int REV = 1056;
   logic [10:0] pcnt_q;
   logic        run_at_pulse_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   // drum pulses since reset modulo one revolution; 0 means position 1 of section 1 is next
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pcnt_q <= 11'h000;
      end else if (drum_pulse_in) begin
         pcnt_q <= (pcnt_q == 11'(REV - 1)) ? 11'h000 : pcnt_q + 11'h001;
      end
   end

   // run level seen at the last drum pulse, since write outputs stand until the next one
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         run_at_pulse_q <= 1'b0;
      end else if (drum_pulse_in) begin
         run_at_pulse_q <= run_out;
      end
   end

   sequence s_rev_start;
      pcnt_q == 11'h001;
   endsequence

   sequence s_pulse_cause;
      $past(drum_pulse_in);
   endsequence

   AST_RDATA_QUIET: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data not zero outside the read answer cycle");
   AST_RUN_STEP: assert property ($changed(run_out) |-> s_pulse_cause)
      else $error("run changed without a drum pulse");
   AST_OVF_STEP: assert property ($changed(ovf_wr_out) |-> s_pulse_cause)
      else $error("z record bit changed without a drum pulse");
   AST_INT_STEP: assert property
      ($changed({integrand_wr_out, integrand_wr_en_out}) |-> s_pulse_cause)
      else $error("integrand record changed without a drum pulse");
   AST_REM_STEP: assert property
      ($changed({remainder_wr_out, remainder_wr_en_out}) |-> s_pulse_cause)
      else $error("remainder record changed without a drum pulse");
   AST_RUN_BOUNDARY: assert property ($changed(run_out) |-> s_rev_start)
      else $error("run changed away from the revolution start");
   AST_INT_EN_RUN: assert property
      (integrand_wr_en_out |-> (run_out || run_at_pulse_q))
      else $error("integrand recorded while not running");
   AST_REM_EN_RUN: assert property
      (remainder_wr_en_out |-> (run_out || run_at_pulse_q))
      else $error("remainder recorded while not running");
   AST_RUN_HOLD: assert property ($rose(run_out) |=> run_out [*8])
      else $error("run dropped right after starting");
endmodule

bind dri_core dri_core_chk u_chk (
   .ref_clk_in          (ref_clk_in),
   .rst_n_in            (rst_n_in),
   .drum_pulse_in       (drum_pulse_in),
   .reg_rd_in           (reg_rd_in),
   .reg_rdata_out       (reg_rdata_out),
   .run_out             (run_out),
   .ovf_wr_out          (ovf_wr_out),
   .integrand_wr_out    (integrand_wr_out),
   .integrand_wr_en_out (integrand_wr_en_out),
   .remainder_wr_out    (remainder_wr_out),
   .remainder_wr_en_out (remainder_wr_en_out)
);
`default_nettype wire

// file: test/dri_drum_model.sv
// drum tracks and clock-track pulse source facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module dri_drum_model #(
   parameter int PER = 4
) (
   input  wire logic clk_in,
   input  wire logic en_in,
   input  wire logic z_inject_in,
   input  wire logic int_wr_in,
   input  wire logic int_wr_en_in,
   input  wire logic rem_wr_in,
   input  wire logic rem_wr_en_in,
   output logic      pulse_out,
   output logic      z_rd_out,
   output logic      int_rd_out,
   output logic      rem_rd_out,
   output logic      dy_out
);
   logic [1055:0] int_trk = '0;
   logic [1055:0] rem_trk = '0;
   int            div = 0;
   int            pos = 0;
   int            prev = 1055;

   initial pulse_out = 1'b0;
   // clock track: one pulse every PER cycles while the drum turns
   always @(posedge clk_in) begin
      div <= (div == PER - 1) ? 0 : div + 1;
      pulse_out <= en_in && (div == PER - 1);
      if (pulse_out) begin
         pos <= (pos == 1055) ? 0 : pos + 1;
         prev <= pos;
         // record heads take what stood over the last pulse time
         if (int_wr_en_in) int_trk[prev] <= int_wr_in;
         if (rem_wr_en_in) rem_trk[prev] <= rem_wr_in;
      end
   end

   // z head is fed by the bench injector so a marker pass can be timed alone
   assign z_rd_out   = z_inject_in;
   assign int_rd_out = int_trk[pos];
   assign rem_rd_out = rem_trk[pos];
   // dy pickup rides on the z injector, so each marker pass also lands one code pickup
   assign dy_out     = z_inject_in;
endmodule
`default_nettype wire

// file: test/tb_dri_core.sv
// self-checking bench for the drum integrator run and fill sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_dri_core;
   typedef struct {logic [2:0] mode; int dz; logic wi; logic wr;} dri_row_t;
   logic        ref_clk_in   = 1'b0;
   logic        rst_n_in     = 1'b0;
   logic        one_btn_in   = 1'b0;
   logic        zero_btn_in  = 1'b0;
   logic [3:0]  reg_addr_in  = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic        drum_en      = 1'b0;
   logic        z_inj        = 1'b0;
   wire logic   drum_pulse_in, ovf_rd_in, integrand_rd_in, remainder_rd_in, dy_pickup_in;
   wire logic   run_out, ovf_wr_out, integrand_wr_out, integrand_wr_en_out;
   wire logic   remainder_wr_out, remainder_wr_en_out;
   wire logic [31:0] reg_rdata_out;
   int          err_count = 0;
   int          checks_done = 0;
   int          pc = 0;
   int          d0, d, pr, t0;
   logic [31:0] rv;
   logic        si, sr;
   // marker shift per mode against idle, and which track a marker pass records
   dri_row_t rows [6] = '{
      '{dri_pkg::MODE_SINGLE_REV, 1, 1'b0, 1'b0},
      '{dri_pkg::MODE_STEP_LEFT, 1, 1'b0, 1'b0},
      '{dri_pkg::MODE_FILL_INTEGRAND, -1, 1'b1, 1'b0},
      '{dri_pkg::MODE_FILL_REMAINDER, -1, 1'b0, 1'b1},
      '{dri_pkg::MODE_STEP_RIGHT, -1, 1'b0, 1'b0},
      '{dri_pkg::MODE_CONTINUOUS, 1, 1'b0, 1'b0}};

   always #2.5 ref_clk_in = ~ref_clk_in;
   // drum pulses seen since reset, the bench's own position reference
   always @(posedge ref_clk_in) pc <= !rst_n_in ? 0 : pc + int'(drum_pulse_in);

   dri_drum_model #(.PER(4)) u_drum (.clk_in(ref_clk_in), .en_in(drum_en),
      .z_inject_in(z_inj), .int_wr_in(integrand_wr_out), .int_wr_en_in(integrand_wr_en_out),
      .rem_wr_in(remainder_wr_out), .rem_wr_en_in(remainder_wr_en_out),
      .pulse_out(drum_pulse_in), .z_rd_out(ovf_rd_in), .int_rd_out(integrand_rd_in),
      .rem_rd_out(remainder_rd_in), .dy_out(dy_pickup_in));

   dri_core uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .drum_pulse_in(drum_pulse_in),
      .one_btn_in(one_btn_in), .zero_btn_in(zero_btn_in), .ovf_rd_in(ovf_rd_in),
      .integrand_rd_in(integrand_rd_in), .remainder_rd_in(remainder_rd_in),
      .dy_pickup_in(dy_pickup_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .run_out(run_out), .ovf_wr_out(ovf_wr_out), .integrand_wr_out(integrand_wr_out),
      .integrand_wr_en_out(integrand_wr_en_out), .remainder_wr_out(remainder_wr_out),
      .remainder_wr_en_out(remainder_wr_en_out));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      @(negedge ref_clk_in);
      v = reg_rdata_out;
   endtask

   task automatic press(input logic one);
      @(posedge ref_clk_in);
      one_btn_in  <= one;
      zero_btn_in <= !one;
      @(posedge ref_clk_in);
      one_btn_in  <= 1'b0;
      zero_btn_in <= 1'b0;
   endtask

   // ends on the edge that consumes the next drum pulse
   task automatic wait_pulse();
      do @(negedge ref_clk_in); while (drum_pulse_in !== 1'b1);
      @(posedge ref_clk_in);
   endtask

   // bounded wait: longer than one start delay plus one revolution
   task automatic wait_run(input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (run_out !== lvl && n < 9000);
      chk({31'h0, run_out}, {31'h0, lvl});
   endtask

   // one z read pulse in, count pulse times until it is rewritten
   task automatic zdelay(output int dd);
      wait_pulse();
      z_inj <= 1'b1;
      wait_pulse();
      z_inj <= 1'b0;
      dd = 0;
      pr = -1;
      si = 1'b0;
      sr = 1'b0;
      repeat (40) begin
         @(negedge ref_clk_in);
         if (ovf_wr_out === 1'b1 && pr < 0) pr = dd;
         if (drum_pulse_in === 1'b1) dd++;
         si |= integrand_wr_en_out & integrand_wr_out;
         sr |= remainder_wr_en_out;
      end
      dd = pr;
   endtask

   function automatic logic [31:0] exp_sec(input int k);
      return 32'((k % 48) + 1) | (32'(((k / 48) % 22) + 1) << 6);
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog well past two revolutions per row plus the counter run, under the cycle budget
   initial begin
      #(90000 * 5);
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      drum_en  <= 1'b1;
      zdelay(d0);
      for (int i = 0; i < 6; i++) begin
         wr(dri_pkg::CTRL_ADDR, {23'h0, 5'h01, 1'b0, rows[i].mode});
         press(1'b1);
         wait_run(1'b1);
         t0 = pc;
         repeat (3) wait_pulse();
         rd(dri_pkg::STATUS_ADDR, rv);
         chk(rv & 32'h0000000f, 32'h00000009);
         zdelay(d);
         chk(d, d0 + rows[i].dz);
         chk({31'h0, si}, {31'h0, rows[i].wi});
         chk({31'h0, sr}, {31'h0, rows[i].wr});
         // the injected pickup fell in the code part, so the tally holds exactly one
         rd(dri_pkg::STATUS_ADDR, rv);
         chk(rv & 32'h000003c0, 32'h00000040);
         if (rows[i].mode != dri_pkg::MODE_CONTINUOUS) begin
            wait_run(1'b0);
            chk(pc - t0, 1056);
         end
         $display("row %0d done", i);
      end
      // reset lands in mid-run of continuous mode with the drum stopped
      @(posedge ref_clk_in);
      drum_en  <= 1'b0;
      rst_n_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(negedge ref_clk_in);
      chk({31'h0, run_out}, 32'h0);
      rd(dri_pkg::CTRL_ADDR, rv);
      chk(rv, 32'(dri_pkg::CTRL_RESET));
      rd(dri_pkg::STATUS_ADDR, rv);
      chk(rv, 32'h0);
      rd(dri_pkg::SECTOR_ADDR, rv);
      chk(rv, exp_sec(pc));
      wr(4'hc, 32'hffffffff);
      rd(4'hc, rv);
      chk(rv, 32'h0);
      wr(dri_pkg::STATUS_ADDR, 32'h000000ff);
      rd(dri_pkg::STATUS_ADDR, rv);
      chk(rv, 32'h0);
      wr(dri_pkg::CTRL_ADDR, 32'h000000bd);
      rd(dri_pkg::CTRL_ADDR, rv);
      chk(rv, 32'h000000bd);
      $display("reset and register map done");
      press(1'b0);
      rd(dri_pkg::STATUS_ADDR, rv);
      chk(rv & 32'h0000000f, 32'h00000002);
      press(1'b1);
      rd(dri_pkg::STATUS_ADDR, rv);
      chk(rv & 32'h0000000f, 32'h0000000a);
      $display("buttons done");
      // counters across one revolution wrap, read with the drum stopped
      @(posedge ref_clk_in);
      drum_en <= 1'b1;
      // armed in continuous mode with the marker switch on: marker only at position 48
      while (pc < 47) @(negedge ref_clk_in);
      chk({31'h0, ovf_wr_out}, 32'h0);
      while (pc < 48) @(negedge ref_clk_in);
      chk({31'h0, ovf_wr_out}, 32'h1);
      while (pc < 1100) @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      drum_en <= 1'b0;
      repeat (12) @(posedge ref_clk_in);
      rd(dri_pkg::SECTOR_ADDR, rv);
      chk(rv, exp_sec(pc));
      $display("counters done");
      wrap_up();
   end
endmodule
`default_nettype wire
